// File: mag_pkg.sv
// Constants, types and register map of the microphone gain control loop.
package mag_pkg;
	// ****************************************
	// Pages and register addresses
	// ****************************************
	localparam logic [6:0] ADDR_PAGE = 7'h00;
	localparam logic [7:0] PAGE_CTRL = 8'h00;
	localparam logic [7:0] PAGE_ANALOG = 8'h01;
	localparam logic [7:0] PAGE_COEF = 8'h04;
	localparam logic [6:0] ADDR_GAIN_STATUS = 7'h24;
	localparam logic [6:0] ADDR_ADC_SAT = 7'h27;
	localparam logic [6:0] ADDR_NOISE_STATUS = 7'h2D;
	localparam logic [6:0] ADDR_ENABLE_TARGET = 7'h56;
	localparam logic [6:0] ADDR_HYST_NOISE = 7'h57;
	localparam logic [6:0] ADDR_MAX_GAIN = 7'h58;
	localparam logic [6:0] ADDR_ATTACK = 7'h59;
	localparam logic [6:0] ADDR_DECAY = 7'h5A;
	localparam logic [6:0] ADDR_NOISE_DEB = 7'h5B;
	localparam logic [6:0] ADDR_SIGNAL_DEB = 7'h5C;
	localparam logic [6:0] ADDR_GAIN_READBACK = 7'h5D;
	localparam logic [6:0] ADDR_FIXED_GAIN = 7'h2F;
	localparam logic [6:0] ADDR_N0_HI = 7'h02;
	localparam logic [6:0] ADDR_N0_LO = 7'h03;
	localparam logic [6:0] ADDR_N1_HI = 7'h04;
	localparam logic [6:0] ADDR_N1_LO = 7'h05;
	localparam logic [6:0] ADDR_D1_HI = 7'h06;
	localparam logic [6:0] ADDR_D1_LO = 7'h07;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int EN_BIT = 7;
	localparam int TARGET_MSB = 6;
	localparam int TARGET_LSB = 4;
	localparam int HYST_MSB = 7;
	localparam int HYST_LSB = 6;
	localparam int NOISE_MSB = 5;
	localparam int NOISE_LSB = 1;
	localparam int GAIN_MSB = 6;
	localparam int NDEB_MSB = 4;
	localparam int SDEB_MSB = 3;
	localparam int LOOP_SAT_BIT = 5;
	localparam int ADC_SAT_BIT = 3;
	localparam int NOISE_BIT = 6;
	localparam int TC_MSB = 7;
	localparam int TC_MANT_LSB = 3;
	localparam int TC_EXP_MSB = 2;
	// ****************************************
	// Reset values and levels
	// ****************************************
	localparam logic [15:0] N0_RESET = 16'h7FFF;
	localparam logic [15:0] N1_RESET = 16'h0000;
	localparam logic [15:0] D1_RESET = 16'h0000;
	localparam logic [7:0] FIXED_GAIN_RESET = 8'h00;
	localparam logic [6:0] GAIN_MAX_CODE = 7'h77;
	localparam logic [15:0] FULL_SCALE = 16'h7FFF;
	// Amplitudes for -5.5 dB down to -24 dB in even steps of about 2.64 dB.
	localparam logic [7:0][15:0] TARGET_AMP = {16'h0810, 16'h0AEF, 16'h0ED3, 16'h141A,
		16'h1B42, 16'h24F5, 16'h321D, 16'h43F3};
	// Amplitudes for -30, -32 and -34 dB; each further 6 dB is one right shift.
	localparam logic [2:0][15:0] NOISE_BASE = {16'h028E, 16'h0337, 16'h040C};
	localparam logic [23:0] ATTACK_BASE = 24'h000020;
	localparam logic [23:0] DECAY_BASE = 24'h000200;
	localparam int STEP_SHIFT = 5;
	localparam int DEB_SHIFT = 2;
	typedef enum logic [1:0] {
		MAG_OFF = 2'b00,
		MAG_TRACK = 2'b01,
		MAG_SILENT = 2'b11
	} mag_state_t;
endpackage

// File: mag_level_filter.sv
// First-order IIR filter that averages the absolute record samples.
`timescale 1ns/1ps
module mag_level_filter #(
	parameter int DW = 16,
	parameter int LW = 24
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic sampleValid,
	input wire logic [DW-1:0] absSample,
	input wire logic [15:0] coefN0,
	input wire logic [15:0] coefN1,
	input wire logic [15:0] coefD1,
	output logic [LW-1:0] level,
	output logic levelValid
);
	localparam int XW = LW + 1;
	localparam int AW = XW + 18;
	logic [LW-1:0] levelReg, levelNext;
	logic signed [XW-1:0] xPrevReg, xPrevNext;
	logic validReg, validNext;
	logic signed [XW-1:0] xNow, yPrev;
	logic signed [AW-1:0] acc;

	// Samples carry eight fraction bits so that the average keeps resolution.
	assign xNow = signed'({1'b0, absSample, (LW - DW)'(0)});
	assign yPrev = signed'({1'b0, levelReg});

	always_comb begin
		// Each operand is widened first so that no product is cut to its operand width.
		acc = AW'(signed'(coefN0)) * AW'(xNow) + AW'(signed'(coefN1)) * AW'(xPrevReg)
			+ AW'(signed'(coefD1)) * AW'(yPrev);
		levelNext = levelReg;
		xPrevNext = xPrevReg;
		validNext = sampleValid;
		if (sampleValid) begin
			xPrevNext = xNow;
			if (acc < 0) begin
				levelNext = '0;
			end else if (|acc[AW-1:LW+15]) begin
				levelNext = '1;
			end else begin
				levelNext = acc[LW+14:15];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			levelReg <= '0;
			xPrevReg <= '0;
			validReg <= 1'b0;
		end else begin
			levelReg <= levelNext;
			xPrevReg <= xPrevNext;
			validReg <= validNext;
		end
	end

	assign level = levelReg;
	assign levelValid = validReg;
endmodule // mag_level_filter

// File: mag_debounce.sv
// Debounce that qualifies a condition held for a programmed number of ticks.
`timescale 1ns/1ps
module mag_debounce #(
	parameter int LW = 8
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic tick,
	input wire logic cond,
	input wire logic [LW-1:0] holdLen,
	output logic qualified
);
	logic [LW-1:0] cntReg, cntNext;
	logic qualReg, qualNext;

	always_comb begin
		cntNext = cntReg;
		qualNext = qualReg;
		if (tick) begin
			if (!cond) begin
				cntNext = '0;
				qualNext = 1'b0;
			end else if (cntReg >= holdLen) begin
				qualNext = 1'b1;
			end else begin
				cntNext = cntReg + 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			cntReg <= '0;
			qualReg <= 1'b0;
		end else begin
			cntReg <= cntNext;
			qualReg <= qualNext;
		end
	end

	assign qualified = qualReg;

	qual_drop_a: assert property (
		@(posedge core_clk) disable iff (rst) tick && !cond |=> !qualified)
		else $error("Debounce stayed qualified after the condition fell.");
endmodule // mag_debounce

// File: mag_gain_loop.sv
// Microphone gain control loop with its control and status registers.
`timescale 1ns/1ps
module mag_gain_loop
	import mag_pkg::*;
#(
	parameter int SW = 16,
	parameter int LW = 24
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic sampleValid,
	input wire logic [SW-1:0] sampleData,
	input wire logic cfgWrEn,
	input wire logic cfgRdEn,
	input wire logic [6:0] cfgAddr,
	input wire logic [7:0] cfgWrData,
	output logic [7:0] cfgRdData,
	output logic [6:0] pgaGain,
	output logic noiseFlag,
	output logic loopSaturated
);
	// ****************************************
	// Control registers
	// ****************************************
	logic [7:0] pageReg, pageNext;
	logic agcEnReg, agcEnNext;
	logic [2:0] targetReg, targetNext;
	logic [1:0] hystReg, hystNext;
	logic [4:0] noiseThrReg, noiseThrNext;
	logic [6:0] maxGainReg, maxGainNext;
	logic [7:0] attackReg, attackNext;
	logic [7:0] decayReg, decayNext;
	logic [4:0] noiseDebReg, noiseDebNext;
	logic [3:0] signalDebReg, signalDebNext;
	logic [7:0] fixedGainReg, fixedGainNext;
	logic [15:0] n0Reg, n0Next, n1Reg, n1Next, d1Reg, d1Next;

	always_comb begin
		pageNext = pageReg;
		agcEnNext = agcEnReg;
		targetNext = targetReg;
		hystNext = hystReg;
		noiseThrNext = noiseThrReg;
		maxGainNext = maxGainReg;
		attackNext = attackReg;
		decayNext = decayReg;
		noiseDebNext = noiseDebReg;
		signalDebNext = signalDebReg;
		fixedGainNext = fixedGainReg;
		n0Next = n0Reg;
		n1Next = n1Reg;
		d1Next = d1Reg;
		if (cfgWrEn) begin
			if (cfgAddr == ADDR_PAGE) begin
				pageNext = cfgWrData;
			end else if (pageReg == PAGE_CTRL) begin
				case (cfgAddr)
					ADDR_ENABLE_TARGET: begin
						agcEnNext = cfgWrData[EN_BIT];
						targetNext = cfgWrData[TARGET_MSB:TARGET_LSB];
					end
					ADDR_HYST_NOISE: begin
						hystNext = cfgWrData[HYST_MSB:HYST_LSB];
						noiseThrNext = cfgWrData[NOISE_MSB:NOISE_LSB];
					end
					ADDR_MAX_GAIN: maxGainNext = cfgWrData[GAIN_MSB:0];
					ADDR_ATTACK: attackNext = cfgWrData;
					ADDR_DECAY: decayNext = cfgWrData;
					ADDR_NOISE_DEB: noiseDebNext = cfgWrData[NDEB_MSB:0];
					ADDR_SIGNAL_DEB: signalDebNext = cfgWrData[SDEB_MSB:0];
					default: ;
				endcase
			end else if (pageReg == PAGE_ANALOG && cfgAddr == ADDR_FIXED_GAIN) begin
				fixedGainNext = cfgWrData;
			end else if (pageReg == PAGE_COEF) begin
				case (cfgAddr)
					ADDR_N0_HI: n0Next = {cfgWrData, n0Reg[7:0]};
					ADDR_N0_LO: n0Next = {n0Reg[15:8], cfgWrData};
					ADDR_N1_HI: n1Next = {cfgWrData, n1Reg[7:0]};
					ADDR_N1_LO: n1Next = {n1Reg[15:8], cfgWrData};
					ADDR_D1_HI: d1Next = {cfgWrData, d1Reg[7:0]};
					ADDR_D1_LO: d1Next = {d1Reg[15:8], cfgWrData};
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			pageReg <= PAGE_CTRL;
			agcEnReg <= 1'b0;
			targetReg <= '0;
			hystReg <= '0;
			noiseThrReg <= '0;
			maxGainReg <= '0;
			attackReg <= '0;
			decayReg <= '0;
			noiseDebReg <= '0;
			signalDebReg <= '0;
			fixedGainReg <= FIXED_GAIN_RESET;
			n0Reg <= N0_RESET;
			n1Reg <= N1_RESET;
			d1Reg <= D1_RESET;
		end else begin
			pageReg <= pageNext;
			agcEnReg <= agcEnNext;
			targetReg <= targetNext;
			hystReg <= hystNext;
			noiseThrReg <= noiseThrNext;
			maxGainReg <= maxGainNext;
			attackReg <= attackNext;
			decayReg <= decayNext;
			noiseDebReg <= noiseDebNext;
			signalDebReg <= signalDebNext;
			fixedGainReg <= fixedGainNext;
			n0Reg <= n0Next;
			n1Reg <= n1Next;
			d1Reg <= d1Next;
		end
	end

	// ****************************************
	// Level measurement and decisions
	// ****************************************
	logic [SW-1:0] absSample;
	logic [LW-1:0] levelReg, targetAmp, noiseAmp, releaseAmp;
	logic levelValid, loud, quiet, noiseQual, signalQual, adcClip;
	logic [15:0] noiseBase;
	logic [6:0] capCode, fixedClamp;
	logic [23:0] attackReload, decayReload;

	// Averaging the magnitude rather than tracking peaks follows speech loudness.
	assign absSample = sampleData[SW-1] ? SW'(-sampleData) : sampleData;
	assign adcClip = sampleValid && absSample >= FULL_SCALE;

	mag_level_filter #(.DW(SW), .LW(LW)) levelFilter (
		.core_clk(core_clk),
		.rst(rst),
		.sampleValid(sampleValid),
		.absSample(absSample),
		.coefN0(n0Reg),
		.coefN1(n1Reg),
		.coefD1(d1Reg),
		.level(levelReg),
		.levelValid(levelValid)
	);

	function automatic logic [23:0] stepReload(input logic [7:0] tc, input logic [23:0] base);
		logic [31:0] t;
		t = ((32'(tc[TC_MSB:TC_MANT_LSB]) * 32'h2 + 32'h1) * 32'(base)) << tc[TC_EXP_MSB:0];
		t = t >> STEP_SHIFT;
		return (t == 32'h0) ? 24'h0 : 24'(t - 32'h1);
	endfunction

	always_comb begin
		targetAmp = {TARGET_AMP[targetReg], 8'h00};
		noiseBase = NOISE_BASE[2'(noiseThrReg % 5'h3)];
		noiseAmp = {noiseBase, 8'h00} >> (noiseThrReg / 5'h3);
		case (hystReg)
			2'h0: releaseAmp = noiseAmp + (noiseAmp >> 3);
			2'h1: releaseAmp = noiseAmp + (noiseAmp >> 2);
			2'h2: releaseAmp = noiseAmp + (noiseAmp >> 1);
			default: releaseAmp = noiseAmp;
		endcase
		loud = levelReg > targetAmp;
		quiet = levelReg < targetAmp;
		capCode = (maxGainReg > GAIN_MAX_CODE) ? GAIN_MAX_CODE : maxGainReg;
		fixedClamp = (fixedGainReg[GAIN_MSB:0] > GAIN_MAX_CODE) ? GAIN_MAX_CODE
			: fixedGainReg[GAIN_MSB:0];
		attackReload = stepReload(attackReg, ATTACK_BASE);
		decayReload = stepReload(decayReg, DECAY_BASE);
	end

	mag_debounce #(.LW(8)) noiseDebounce (
		.core_clk(core_clk),
		.rst(rst),
		.tick(levelValid),
		.cond(levelReg < noiseAmp),
		.holdLen(8'({noiseDebReg, DEB_SHIFT'(0)})),
		.qualified(noiseQual)
	);

	mag_debounce #(.LW(8)) signalDebounce (
		.core_clk(core_clk),
		.rst(rst),
		.tick(levelValid),
		.cond(levelReg > releaseAmp),
		.holdLen(8'({signalDebReg, DEB_SHIFT'(0)})),
		.qualified(signalQual)
	);

	// ****************************************
	// Gain loop
	// ****************************************
	mag_state_t stateReg, stateNext;
	logic [6:0] gainReg, gainNext;
	logic [23:0] stepReg, stepNext;
	logic lastLoudReg, lastLoudNext, satReg, satNext, noiseReg, noiseNext;

	// Every change waits for a sample, so register writes act on the next one.
	always_comb begin
		stateNext = stateReg;
		gainNext = gainReg;
		stepNext = stepReg;
		lastLoudNext = lastLoudReg;
		satNext = satReg;
		noiseNext = noiseReg;
		if (levelValid) begin
			case (stateReg)
				MAG_OFF: begin
					gainNext = fixedClamp;
					satNext = 1'b0;
					noiseNext = 1'b0;
					stepNext = '0;
					if (agcEnReg) begin
						stateNext = MAG_TRACK;
					end
				end
				MAG_TRACK: begin
					if (!agcEnReg) begin
						stateNext = MAG_OFF;
						gainNext = fixedClamp;
					end else if (noiseQual) begin
						stateNext = MAG_SILENT;
						noiseNext = 1'b1;
						satNext = 1'b0;
					end else if (loud || quiet) begin
						lastLoudNext = loud;
						satNext = quiet && gainReg >= capCode;
						if (loud != lastLoudReg) begin
							stepNext = loud ? attackReload : decayReload;
						end else if (stepReg != '0) begin
							stepNext = stepReg - 24'h1;
						end else begin
							stepNext = loud ? attackReload : decayReload;
							if (loud && gainReg != '0) begin
								gainNext = gainReg - 7'h1;
							end else if (!loud && gainReg < capCode) begin
								gainNext = gainReg + 7'h1;
							end
						end
					end
				end
				MAG_SILENT: begin
					if (!agcEnReg) begin
						stateNext = MAG_OFF;
						gainNext = fixedClamp;
						noiseNext = 1'b0;
					end else if (signalQual) begin
						stateNext = MAG_TRACK;
						noiseNext = 1'b0;
						stepNext = '0;
					end else if (gainReg != '0) begin
						gainNext = gainReg - 7'h1;
					end
				end
				default: stateNext = MAG_OFF;
			endcase
			if (stateNext != MAG_OFF && gainNext > capCode) begin
				gainNext = capCode;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			stateReg <= MAG_OFF;
			gainReg <= '0;
			stepReg <= '0;
			lastLoudReg <= 1'b0;
			satReg <= 1'b0;
			noiseReg <= 1'b0;
		end else begin
			stateReg <= stateNext;
			gainReg <= gainNext;
			stepReg <= stepNext;
			lastLoudReg <= lastLoudNext;
			satReg <= satNext;
			noiseReg <= noiseNext;
		end
	end

	// ****************************************
	// Register read and sticky clip flag
	// ****************************************
	logic [7:0] rdReg, rdNext;
	logic adcSatReg, adcSatNext;

	always_comb begin
		rdNext = rdReg;
		adcSatNext = adcSatReg | adcClip;
		if (cfgRdEn) begin
			rdNext = 8'h00;
			if (cfgAddr == ADDR_PAGE) begin
				rdNext = pageReg;
			end else if (pageReg == PAGE_CTRL) begin
				case (cfgAddr)
					ADDR_GAIN_STATUS: rdNext[LOOP_SAT_BIT] = satReg;
					ADDR_ADC_SAT: begin
						rdNext[ADC_SAT_BIT] = adcSatReg;
						adcSatNext = adcClip;
					end
					ADDR_NOISE_STATUS: rdNext[NOISE_BIT] = noiseReg;
					ADDR_ENABLE_TARGET: begin
						rdNext[EN_BIT] = agcEnReg;
						rdNext[TARGET_MSB:TARGET_LSB] = targetReg;
					end
					ADDR_HYST_NOISE: begin
						rdNext[HYST_MSB:HYST_LSB] = hystReg;
						rdNext[NOISE_MSB:NOISE_LSB] = noiseThrReg;
					end
					ADDR_MAX_GAIN: rdNext[GAIN_MSB:0] = maxGainReg;
					ADDR_ATTACK: rdNext = attackReg;
					ADDR_DECAY: rdNext = decayReg;
					ADDR_NOISE_DEB: rdNext[NDEB_MSB:0] = noiseDebReg;
					ADDR_SIGNAL_DEB: rdNext[SDEB_MSB:0] = signalDebReg;
					ADDR_GAIN_READBACK: rdNext[GAIN_MSB:0] = gainReg;
					default: ;
				endcase
			end else if (pageReg == PAGE_ANALOG && cfgAddr == ADDR_FIXED_GAIN) begin
				rdNext = fixedGainReg;
			end else if (pageReg == PAGE_COEF) begin
				case (cfgAddr)
					ADDR_N0_HI: rdNext = n0Reg[15:8];
					ADDR_N0_LO: rdNext = n0Reg[7:0];
					ADDR_N1_HI: rdNext = n1Reg[15:8];
					ADDR_N1_LO: rdNext = n1Reg[7:0];
					ADDR_D1_HI: rdNext = d1Reg[15:8];
					ADDR_D1_LO: rdNext = d1Reg[7:0];
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			rdReg <= 8'h00;
			adcSatReg <= 1'b0;
		end else begin
			rdReg <= rdNext;
			adcSatReg <= adcSatNext;
		end
	end

	assign cfgRdData = rdReg;
	assign pgaGain = gainReg;
	assign noiseFlag = noiseReg;
	assign loopSaturated = satReg;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	tick_only_a: assert property (
		!levelValid |=> $stable(gainReg))
		else $error("Gain changed outside a sample tick.");
	gain_cap_a: assert property (
		levelValid && agcEnReg && stateReg != MAG_OFF && !cfgWrEn |=> gainReg <= capCode)
		else $error("Loop gain above the cap.");
	fixed_gain_a: assert property (
		levelValid && !agcEnReg && !cfgWrEn |=> gainReg == fixedClamp)
		else $error("Fixed gain not applied with loop off.");
	enter_silence_a: assert property (
		levelValid && stateReg == MAG_TRACK && agcEnReg && noiseQual
		|=> noiseReg && stateReg == MAG_SILENT)
		else $error("Silence not flagged below the noise threshold.");
	silence_step_a: assert property (
		levelValid && stateReg == MAG_SILENT && agcEnReg && !signalQual && gainReg != '0
		|=> gainReg < $past(gainReg))
		else $error("Gain not stepped down in silence.");
	silence_hold_a: assert property (
		stateReg == MAG_SILENT && agcEnReg && !signalQual && gainReg == '0 |=> gainReg == '0)
		else $error("Gain left 0 dB while still silent.");
	attack_step_a: assert property (
		levelValid && stateReg == MAG_TRACK && agcEnReg && !noiseQual && loud
		&& lastLoudReg && stepReg == '0 && gainReg != '0 |=> gainReg < $past(gainReg))
		else $error("Attack step missing.");
	decay_step_a: assert property (
		levelValid && stateReg == MAG_TRACK && agcEnReg && !noiseQual && quiet
		&& !lastLoudReg && stepReg == '0 && gainReg < capCode && !cfgWrEn
		|=> gainReg == $past(gainReg) + 7'h1)
		else $error("Decay step missing.");
	readback_a: assert property (
		cfgRdEn && pageReg == PAGE_CTRL && cfgAddr == ADDR_GAIN_READBACK
		|=> cfgRdData == {1'b0, $past(gainReg)})
		else $error("Applied gain readback wrong.");

	silence_c: cover property (stateReg == MAG_TRACK ##1 stateReg == MAG_SILENT);
	attack_c: cover property (stateReg == MAG_TRACK && gainNext < gainReg);
	decay_c: cover property (stateReg == MAG_TRACK && gainNext > gainReg);
	sat_c: cover property ($rose(satReg));
endmodule // mag_gain_loop

// File: mag_record_model.sv
// Record-path model that feeds one signed sample per period to the gain loop.
`timescale 1ns/1ps
module mag_record_model #(
	parameter int PERIOD = 4
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [15:0] amp,
	output logic sampleValid,
	output logic [15:0] sampleData
);
	logic [7:0] phaseCnt_reg;
	logic negPhase_reg;
	logic [15:0] value;
	// The sign alternates so that only the mean of magnitudes stays steady.
	assign value = negPhase_reg ? 16'h0000 - amp : amp;
	assign sampleValid = !rst && phaseCnt_reg == 8'(PERIOD - 1);
	// Between samples the bus shows the inverse, so a stale value is never taken.
	assign sampleData = sampleValid ? value : ~value;
	always_ff @(posedge core_clk) begin
		if (rst) begin
			phaseCnt_reg <= 8'h00;
			negPhase_reg <= 1'b0;
		end else begin
			phaseCnt_reg <= sampleValid ? 8'h00 : phaseCnt_reg + 8'h01;
			if (sampleValid) begin
				negPhase_reg <= ~negPhase_reg;
			end
		end
	end
endmodule // mag_record_model

// File: tb_top.sv
// Self-checking testbench of the microphone gain control loop.
`timescale 1ns/1ps
module tb_top;
	import mag_pkg::*;
	typedef struct {logic [6:0] a; logic [7:0] w; logic [7:0] e;} mag_row_t;
	logic core_clk, rst, sampleValid, cfgWrEn, cfgRdEn, noiseFlag, loopSaturated;
	logic [15:0] sampleData, amp;
	logic [6:0] cfgAddr, pgaGain;
	logic [7:0] cfgWrData, cfgRdData, rdv;
	int n_fail, checked;
	mag_row_t rows[9] = '{'{ADDR_ENABLE_TARGET, 8'h70, 8'h70}, '{ADDR_HYST_NOISE, 8'hFF, 8'hFE},
		'{ADDR_MAX_GAIN, 8'hFF, 8'h7F}, '{ADDR_ATTACK, 8'hA5, 8'hA5}, '{ADDR_DECAY, 8'h5A, 8'h5A},
		'{ADDR_NOISE_DEB, 8'hFF, 8'h1F}, '{ADDR_SIGNAL_DEB, 8'hFF, 8'h0F},
		'{ADDR_GAIN_READBACK, 8'hFF, 8'h25}, '{7'h33, 8'hFF, 8'h00}};
	mag_record_model mag_record_model_inst (.core_clk(core_clk), .rst(rst), .amp(amp),
		.sampleValid(sampleValid), .sampleData(sampleData));
	mag_gain_loop mag_gain_loop_inst (.core_clk(core_clk), .rst(rst), .sampleValid(sampleValid),
		.sampleData(sampleData), .cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn), .cfgAddr(cfgAddr),
		.cfgWrData(cfgWrData), .cfgRdData(cfgRdData), .pgaGain(pgaGain),
		.noiseFlag(noiseFlag), .loopSaturated(loopSaturated));
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	// ****************************************
	// Bus and check tasks
	// ****************************************
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		cfgWrEn = 1'b1;
		cfgAddr = a;
		cfgWrData = d;
		@(posedge core_clk);
		#1;
		cfgWrEn = 1'b0;
		// One idle edge keeps back-to-back strobes from being assigned twice in a step.
		@(posedge core_clk);
		#1;
	endtask
	task automatic rd(input logic [6:0] a);
		cfgRdEn = 1'b1;
		cfgAddr = a;
		@(posedge core_clk);
		#1;
		cfgRdEn = 1'b0;
		rdv = cfgRdData;
		@(posedge core_clk);
		#1;
	endtask
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic waitGain(input logic [6:0] g, input int lim);
		for (int i = 0; i < lim && pgaGain !== g; i++) begin
			@(posedge core_clk);
			#1;
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		#400000;
		n_fail++;
		conclude();
	end
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		{rst, cfgWrEn, cfgRdEn, cfgAddr, cfgWrData, amp} = {1'b1, 2'b00, 7'h00, 8'h00, 16'h1000};
		idle(20);
		rst = 1'b0;
		rd(ADDR_ENABLE_TARGET);
		chk("enable reset", rdv, 8'h00);
		wr(ADDR_PAGE, PAGE_COEF);
		rd(ADDR_N0_HI);
		chk("n0 high", rdv, N0_RESET[15:8]);
		rd(ADDR_N0_LO);
		chk("n0 low", rdv, N0_RESET[7:0]);
		wr(ADDR_PAGE, PAGE_ANALOG);
		wr(ADDR_FIXED_GAIN, 8'h7F);
		idle(12);
		chk("fixed clamp", {1'b0, pgaGain}, 8'h77);
		wr(ADDR_FIXED_GAIN, 8'h25);
		idle(12);
		chk("fixed gain", {1'b0, pgaGain}, 8'h25);
		wr(ADDR_PAGE, PAGE_CTRL);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w);
			rd(rows[i].a);
			chk("register", rdv, rows[i].e);
		end
		// Threshold stays at -30 dB so a small cap is allowed.
		wr(ADDR_HYST_NOISE, 8'h00);
		wr(ADDR_MAX_GAIN, 8'h04);
		wr(ADDR_ATTACK, 8'h00);
		wr(ADDR_DECAY, 8'h00);
		wr(ADDR_NOISE_DEB, 8'h00);
		wr(ADDR_SIGNAL_DEB, 8'h00);
		wr(ADDR_ENABLE_TARGET, 8'h80);
		waitGain(7'h04, 3000);
		idle(300);
		chk("gain at cap", {1'b0, pgaGain}, 8'h04);
		chk("saturated", {7'h00, loopSaturated}, 8'h01);
		rd(ADDR_GAIN_STATUS);
		chk("sat status", rdv & 8'h20, 8'h20);
		rd(ADDR_GAIN_READBACK);
		chk("readback", rdv, 8'h04);
		amp = 16'h6000;
		waitGain(7'h02, 100);
		chk("attack", {1'b0, pgaGain}, 8'h02);
		amp = 16'h0000;
		waitGain(7'h00, 200);
		chk("silence flag", {7'h00, noiseFlag}, 8'h01);
		// Gain status is not read while silence is flagged.
		rd(ADDR_NOISE_STATUS);
		chk("noise status", rdv & 8'h40, 8'h40);
		idle(200);
		chk("held at zero", {1'b0, pgaGain}, 8'h00);
		amp = 16'h7FFF;
		idle(40);
		chk("signal back", {7'h00, noiseFlag}, 8'h00);
		amp = 16'h4000;
		idle(8);
		rd(ADDR_ADC_SAT);
		chk("clip sticky", rdv & 8'h08, 8'h08);
		rd(ADDR_ADC_SAT);
		chk("clip cleared", rdv & 8'h08, 8'h00);
		waitGain(7'h04, 600);
		idle(80);
		chk("decay to cap", {1'b0, pgaGain}, 8'h04);
		conclude();
	end
endmodule // tb_top
